// *** rtl/sfdp_pkg.sv ***
// constants, command codes and types shared by the discovery and array read front end
package sfdp_pkg;
    // address and boundary geometry
    localparam int SFDP_AW = 32;            // widest array address
    localparam int SFDP_DIE_BITS = 25;      // one 256Mb die is 2^25 bytes
    localparam int SFDP_TBL_BITS = 11;      // discovery table wraps at 2048 bytes
    localparam logic [5:0] SFDP_ABITS3 = 6'h18; // address bits in three-byte mode
    localparam logic [5:0] SFDP_ABITS4 = 6'h20; // address bits in four-byte mode
    localparam logic [4:0] SFDP_CMD_LAST = 5'h07; // last cycle of the 8-bit opcode
    localparam logic [7:0] SFDP_RSVD = 8'hff;     // unused discovery bytes read as ones

    // array read opcodes, three-byte forms follow the mode, four-byte forms force 32 bits
    localparam logic [7:0] SFDP_OP_READ = 8'h03;
    localparam logic [7:0] SFDP_OP_FAST = 8'h0b;
    localparam logic [7:0] SFDP_OP_DOUT = 8'h3b;
    localparam logic [7:0] SFDP_OP_DIO = 8'hbb;
    localparam logic [7:0] SFDP_OP_QOUT = 8'h6b;
    localparam logic [7:0] SFDP_OP_QIO = 8'heb;
    localparam logic [7:0] SFDP_OP_READ4 = 8'h13;
    localparam logic [7:0] SFDP_OP_FAST4 = 8'h0c;
    localparam logic [7:0] SFDP_OP_DOUT4 = 8'h3c;
    localparam logic [7:0] SFDP_OP_DIO4 = 8'hbc;
    localparam logic [7:0] SFDP_OP_QOUT4 = 8'h6c;
    localparam logic [7:0] SFDP_OP_QIO4 = 8'hec;

    // dummy cycles before the first output byte
    localparam logic [4:0] SFDP_DUMMY_DISC = 5'h08;
    localparam logic [4:0] SFDP_DUMMY_READ = 5'h00;
    localparam logic [4:0] SFDP_DUMMY_FAST = 5'h08;
    localparam logic [4:0] SFDP_DUMMY_QIO = 5'h09;
    localparam logic [4:0] SFDP_DUMMY_QOUT = 5'h07;
    localparam logic [4:0] SFDP_DUMMY_DOUT = 5'h07;
    localparam logic [4:0] SFDP_DUMMY_DIO = 5'h07;

    // decoded shape of one read command
    typedef struct packed {
        logic known;        // opcode is a read this block serves
        logic disc;         // discovery table instead of the array
        logic force3;       // always three address bytes
        logic force4;       // always four address bytes
        logic [1:0] aShift; // log2 of address lanes
        logic [1:0] dShift; // log2 of data lanes
        logic [4:0] dummy;  // dummy cycles
    } sfdp_cmd_s;

    // frame phases on the link clock
    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} sfdp_state_e;
endpackage

// *** rtl/sfdp_sync2.sv ***
// two-stage synchroniser for a level crossing into a clock domain
`timescale 1ns/1ns
`default_nettype none
module sfdp_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta; // first stage, read only by the second

    // both stages clear to a constant under reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// *** rtl/sfdp_rom.sv ***
// constant discovery parameter table, one byte per index
`timescale 1ns/1ns
`default_nettype none
module sfdp_rom (
    input wire logic [sfdp_pkg::SFDP_TBL_BITS-1:0] idx,
    output logic [7:0] dat
);
    import sfdp_pkg::*;

    // fixed content, no write path exists
    always_comb begin
        unique case (idx)
            11'h000: dat = 8'h53; // signature
            11'h001: dat = 8'h46;
            11'h002: dat = 8'h44;
            11'h003: dat = 8'h50;
            11'h004: dat = 8'h00; // revision
            11'h005: dat = 8'h01;
            11'h006: dat = 8'h00; // header count
            11'h008: dat = 8'h00; // parameter header
            11'h009: dat = 8'h00;
            11'h00a: dat = 8'h01;
            11'h00b: dat = 8'h09;
            11'h00c: dat = 8'h30;
            11'h00d: dat = 8'h00;
            11'h00e: dat = 8'h00;
            11'h030: dat = {3'b111, 1'b0, 1'b0, 1'b1, 2'b01};
            11'h031: dat = 8'h20;
            11'h032: dat = {1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'b01, 1'b1};
            11'h037: dat = 8'h1f; // size, other bytes are ones
            11'h038: dat = {3'b001, SFDP_DUMMY_QIO};
            11'h039: dat = SFDP_OP_QIO;
            11'h03a: dat = {3'b001, SFDP_DUMMY_QOUT};
            11'h03b: dat = SFDP_OP_QOUT;
            11'h03c: dat = {3'b001, SFDP_DUMMY_DOUT};
            11'h03d: dat = SFDP_OP_DOUT;
            11'h03e: dat = {3'b001, SFDP_DUMMY_DIO};
            11'h03f: dat = SFDP_OP_DIO;
            11'h046: dat = {3'b001, SFDP_DUMMY_DIO};
            11'h047: dat = SFDP_OP_DIO;
            11'h04a: dat = {3'b001, SFDP_DUMMY_QIO};
            11'h04b: dat = SFDP_OP_QIO;
            11'h04c: dat = 8'h0c;
            11'h04d: dat = 8'h20;
            11'h04e: dat = 8'h10;
            11'h04f: dat = 8'hd8;
            11'h050, 11'h051, 11'h052, 11'h053: dat = 8'h00;
            // reserved bytes and flags read as ones
            default: dat = SFDP_RSVD;
        endcase
    end
endmodule
`default_nettype wire

// *** rtl/sfdp_flash_read.sv ***
// serial read front end: discovery table and array read addressing for a two-die flash
//
// Operation
// - byte 30h: erase code, granularity, flags
// - 4KB erase opcode at 31h, 4Dh
// - sector type 2 is 64KB, D8h
// - bytes 50h-53h read zero
// - byte 32h lists supported fast reads
// - quad I/O: nine dummies, opcode EBh
// - quad output: seven dummies, opcode 6Bh
// - dual output: seven dummies, opcode 3Bh
// - dual I/O: seven dummies, opcode BBh
// - byte 40h advertises two/four-line fast read
// - two-line fast read entry at 46h
// - four-line fast read entry at 4Ah
// - three-byte addressing after power-up
// - four-byte mode uses 32 address bits
// - width set by config or command
// - reads wrap inside the same die
// - discovery: 3 bytes, 8 dummies, 2KB wrap
// - address latched rising, advances per byte
`timescale 1ns/1ns
`default_nettype none
module sfdp_flash_read #(
    parameter logic [7:0] OP_DISC = 8'h5a,  // discovery read opcode
    parameter logic [7:0] OP_EN4 = 8'hb7,   // enter four-byte address mode
    parameter logic [7:0] OP_EX4 = 8'he9    // leave four-byte address mode
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic nvAddr4,
    output logic addr4Status,
    output logic linkBusy,
    input wire logic sclk,
    input wire logic csN,
    input wire logic [3:0] dqIn,
    output logic [3:0] dqOut,
    output logic [3:0] dqOeN,
    output logic [sfdp_pkg::SFDP_AW-1:0] arrayAddr,
    input wire logic [7:0] arrayData
);
    import sfdp_pkg::*;

    // ---------------- helpers ----------------

    // build one command descriptor
    function automatic sfdp_cmd_s mk(input logic disc, input logic f3, input logic f4,
                                     input logic [1:0] as, input logic [1:0] ds,
                                     input logic [4:0] dm);
        sfdp_cmd_s c;
        c.known = 1'b1;
        c.disc = disc;
        c.force3 = f3;
        c.force4 = f4;
        c.aShift = as;
        c.dShift = ds;
        c.dummy = dm;
        return c;
    endfunction

    // opcode to command shape; anything else is not served
    function automatic sfdp_cmd_s decode(input logic [7:0] op);
        sfdp_cmd_s c;
        c = '0;
        case (op)
            // discovery always three bytes, eight dummies
            OP_DISC: c = mk(1'b1, 1'b1, 1'b0, 2'd0, 2'd0, SFDP_DUMMY_DISC);
            SFDP_OP_READ, SFDP_OP_READ4:
                c = mk(1'b0, 1'b0, op == SFDP_OP_READ4, 2'd0, 2'd0, SFDP_DUMMY_READ);
            SFDP_OP_FAST, SFDP_OP_FAST4:
                c = mk(1'b0, 1'b0, op == SFDP_OP_FAST4, 2'd0, 2'd0, SFDP_DUMMY_FAST);
            SFDP_OP_DOUT, SFDP_OP_DOUT4:
                c = mk(1'b0, 1'b0, op == SFDP_OP_DOUT4, 2'd0, 2'd1, SFDP_DUMMY_DOUT);
            SFDP_OP_DIO, SFDP_OP_DIO4:
                c = mk(1'b0, 1'b0, op == SFDP_OP_DIO4, 2'd1, 2'd1, SFDP_DUMMY_DIO);
            SFDP_OP_QOUT, SFDP_OP_QOUT4:
                c = mk(1'b0, 1'b0, op == SFDP_OP_QOUT4, 2'd0, 2'd2, SFDP_DUMMY_QOUT);
            SFDP_OP_QIO, SFDP_OP_QIO4:
                c = mk(1'b0, 1'b0, op == SFDP_OP_QIO4, 2'd2, 2'd2, SFDP_DUMMY_QIO);
            default: c = '0;
        endcase
        return c;
    endfunction

    // lanes of one output slot; one-line data leaves on the second lane
    function automatic logic [3:0] slice(input logic [7:0] b, input logic [2:0] ph,
                                         input logic [1:0] ds);
        logic [7:0] s;
        s = b << 3'(ph << ds);
        case (ds)
            2'd0: slice = {2'b00, s[7], 1'b0};
            2'd1: slice = {2'b00, s[7:6]};
            default: slice = s[7:4];
        endcase
    endfunction

    // active-low enables matching the lanes driven by slice
    function automatic logic [3:0] laneOeN(input logic [1:0] ds);
        case (ds)
            2'd0: laneOeN = 4'hd;
            2'd1: laneOeN = 4'hc;
            default: laneOeN = 4'h0;
        endcase
    endfunction

    // ---------------- declarations ----------------
    logic frameRst;            // whole frame logic clears while deselected
    sfdp_state_e state;        // frame phase
    logic [5:0] cnt;           // cycle counter inside a phase
    logic [6:0] cmdSh;         // opcode bits collected so far
    sfdp_cmd_s info;           // decoded command of this frame
    logic [7:0] next_cmd;      // opcode including the bit on the wire now
    sfdp_cmd_s nextInfo;       // decode of next_cmd
    logic [2:0] ph;            // output slot within the current byte
    logic [2:0] lastPh;        // last slot of a byte for the data width
    logic [7:0] curByte;       // byte being shifted out
    logic [7:0] srcByte;       // byte at the current address
    logic [7:0] romByte;       // table byte at the current index
    logic [5:0] addrLast;      // last address cycle for this command
    logic use4;                // this frame takes four address bytes
    logic addr4Set;            // a mode command has overridden the config
    logic addr4Cmd;            // value chosen by the last mode command
    logic addr4Eff;            // width in force, registered for the crossing
    logic nvReg;               // config bit held on the system clock
    logic nvSync;              // config bit seen on the link clock
    logic a4Sync;              // effective width seen on the system clock
    logic selSync;             // frame active seen on the system clock, low after reset

    assign frameRst = rst | csN;
    assign next_cmd = {cmdSh, dqIn[0]};
    assign nextInfo = decode(next_cmd);
    assign lastPh = 3'(3'd7 >> info.dShift);
    assign srcByte = info.disc ? romByte : arrayData;

    // three bytes unless forced or four-byte mode in force
    assign use4 = info.force4 | (addr4Eff & ~info.force3);
    assign addrLast = 6'((use4 ? SFDP_ABITS4 : SFDP_ABITS3) >> info.aShift) - 6'd1;

    // ---------------- constant table ----------------
    // table indexed by the low address bits
    sfdp_rom u_rom (
        .idx(arrayAddr[SFDP_TBL_BITS-1:0]),
        .dat(romByte)
    );

    // ---------------- system clock side ----------------

    // config bit registered at its source so the crossing sees a clean level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nvReg <= 1'b0;
        end else begin
            nvReg <= nvAddr4;
        end
    end

    // width in force and link activity back onto the system clock
    // activity is carried active high so the cleared sync matches an idle link
    sfdp_sync2 #(.W(2)) u_syncToSys (
        .clk(mclk),
        .rst(rst),
        .d({addr4Eff, ~csN}),
        .q({a4Sync, selSync})
    );

    // status outputs straight from flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr4Status <= 1'b0;
            linkBusy <= 1'b0;
        end else begin
            addr4Status <= a4Sync;
            linkBusy <= selSync;
        end
    end

    // ---------------- link clock side ----------------

    // config level into the link domain; only settles once the link clock runs
    sfdp_sync2 #(.W(1)) u_syncToLink (
        .clk(sclk),
        .rst(rst),
        .d(nvReg),
        .q(nvSync)
    );

    // address width: a mode command overrides the config until the next reset
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            addr4Set <= 1'b0;
            addr4Cmd <= 1'b0;
            addr4Eff <= 1'b0;
        end else begin
            if (!csN && state == ST_CMD && cnt == 6'(SFDP_CMD_LAST)) begin
                if (next_cmd == OP_EN4) begin
                    addr4Set <= 1'b1;
                    addr4Cmd <= 1'b1;
                end else if (next_cmd == OP_EX4) begin
                    addr4Set <= 1'b1;
                    addr4Cmd <= 1'b0;
                end
            end
            addr4Eff <= addr4Set ? addr4Cmd : nvSync;
        end
    end

    // frame phase sequencing; deselect drops everything back to the opcode phase
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            state <= ST_CMD;
            cnt <= 6'd0;
        end else begin
            unique case (state)
                ST_CMD: begin
                    if (cnt == 6'(SFDP_CMD_LAST)) begin
                        cnt <= 6'd0;
                        // unknown opcodes and mode commands sit out the frame
                        state <= nextInfo.known ? ST_ADDR : ST_IGNORE;
                    end else begin
                        cnt <= cnt + 6'd1;
                    end
                end
                ST_ADDR: begin
                    if (cnt == addrLast) begin
                        cnt <= 6'd0;
                        state <= (info.dummy == 5'd0) ? ST_DATA : ST_DUMMY;
                    end else begin
                        cnt <= cnt + 6'd1;
                    end
                end
                ST_DUMMY: begin
                    // dummy count from the decoded command
                    if (cnt == {1'b0, info.dummy} - 6'd1) begin
                        cnt <= 6'd0;
                        state <= ST_DATA;
                    end else begin
                        cnt <= cnt + 6'd1;
                    end
                end
                ST_DATA: begin
                    // output runs until deselect
                    state <= ST_DATA;
                end
                ST_IGNORE: begin
                    state <= ST_IGNORE;
                end
            endcase
        end
    end

    // opcode collection and decode, one bit per rising edge on the first lane
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            cmdSh <= 7'd0;
            info <= '0;
        end else if (state == ST_CMD) begin
            cmdSh <= next_cmd[6:0];
            if (cnt == 6'(SFDP_CMD_LAST)) begin
                info <= nextInfo;
            end
        end
    end

    // address shift-in and advance
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            arrayAddr <= '0;
        end else if (state == ST_ADDR) begin
            // address bits latched on the rising edge
            case (info.aShift)
                2'd0: arrayAddr <= {arrayAddr[SFDP_AW-2:0], dqIn[0]};
                2'd1: arrayAddr <= {arrayAddr[SFDP_AW-3:0], dqIn[1:0]};
                default: arrayAddr <= {arrayAddr[SFDP_AW-5:0], dqIn[3:0]};
            endcase
        end else if (state == ST_DATA && ph == lastPh) begin
            if (info.disc) begin
                // table index wraps at the 2KB boundary
                arrayAddr <= {arrayAddr[SFDP_AW-1:SFDP_TBL_BITS],
                              arrayAddr[SFDP_TBL_BITS-1:0] + 11'd1};
            end else begin
                // wrap to the start of the same die
                arrayAddr <= {arrayAddr[SFDP_AW-1:SFDP_DIE_BITS],
                              arrayAddr[SFDP_DIE_BITS-1:0] + 25'd1};
            end
        end
    end

    // byte capture and slot counting during output
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            ph <= 3'd0;
            curByte <= 8'h00;
        end else if (state == ST_DATA) begin
            // hold the byte after its first slot; the address moves on at the last
            if (ph == 3'd0) begin
                curByte <= srcByte;
            end
            ph <= (ph == lastPh) ? 3'd0 : ph + 3'd1;
        end
    end

    // pins change on the falling edge so the host samples a settled value on the rising one
    always_ff @(negedge sclk or posedge frameRst) begin
        if (frameRst) begin
            dqOut <= 4'h0;
            dqOeN <= 4'hf;
        end else if (state == ST_DATA) begin
            // most significant bit first on the active lanes
            dqOut <= slice((ph == 3'd0) ? srcByte : curByte, ph, info.dShift);
            dqOeN <= laneOeN(info.dShift);
        end else begin
            // lanes stay released while the host owns them
            dqOut <= 4'h0;
            dqOeN <= 4'hf;
        end
    end
endmodule
`default_nettype wire

// *** sim/sfdp_array_model.sv ***
// array storage seen by the read front end, a fixed address pattern
`timescale 1ns/1ns
`default_nettype none
module sfdp_array_model (
    input wire logic [sfdp_pkg::SFDP_AW-1:0] arrayAddr,
    output logic [7:0] arrayData
);
    import sfdp_pkg::*;
    // mixing the die bits in makes a wrong die or wrap visible
    assign arrayData = arrayAddr[7:0] ^ arrayAddr[31:24] ^ arrayAddr[23:16];
endmodule
`default_nettype wire

// *** sim/sfdp_flash_read_checker.sv ***
// concurrent checks on the read front end ports
`timescale 1ns/1ns
`default_nettype none
module sfdp_flash_read_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic nvAddr4,
    input wire logic addr4Status,
    input wire logic linkBusy,
    input wire logic sclk,
    input wire logic csN,
    input wire logic [3:0] dqIn,
    input wire logic [3:0] dqOut,
    input wire logic [3:0] dqOeN,
    input wire logic [sfdp_pkg::SFDP_AW-1:0] arrayAddr,
    input wire logic [7:0] arrayData
);
    import sfdp_pkg::*;
    logic [15:0] edgeCnt; // rising link edges in this frame, saturating
    // cleared by deselect so every frame counts from zero
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            edgeCnt <= 16'h0000;
        end else if (edgeCnt != 16'hffff) begin
            edgeCnt <= edgeCnt + 16'h0001;
        end
    end
    property p_idle_oe;
        @(posedge mclk) disable iff (rst) csN && $past(csN) |-> dqOeN == 4'hf;
    endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("lanes driven while deselected");
    property p_idle_addr;
        @(posedge mclk) disable iff (rst) csN && $past(csN) |-> arrayAddr == 32'h00000000;
    endproperty
    a_idle_addr: assert property (p_idle_addr) else $error("address held while deselected");
    property p_busy_hi;
        @(posedge mclk) disable iff (rst) (!csN) [*5] |-> linkBusy;
    endproperty
    a_busy_hi: assert property (p_busy_hi) else $error("busy missing in frame");
    property p_busy_lo;
        @(posedge mclk) disable iff (rst) csN [*5] |-> !linkBusy;
    endproperty
    a_busy_lo: assert property (p_busy_lo) else $error("busy stuck after frame");
    property p_upper_fixed;
        @(posedge sclk) disable iff (rst)
            dqOeN != 4'hf && $past(dqOeN) != 4'hf |-> $stable(arrayAddr[31:25]);
    endproperty
    a_upper_fixed: assert property (p_upper_fixed) else $error("read crossed into other die");
    property p_step;
        @(posedge sclk) disable iff (rst)
            dqOeN != 4'hf && $past(dqOeN) != 4'hf && $changed(arrayAddr) |->
            arrayAddr[24:0] == $past(arrayAddr[24:0]) + 25'h1 || arrayAddr[10:0] == 11'h000;
    endproperty
    a_step: assert property (p_step) else $error("address step not one");
    property p_first_out;
        @(posedge sclk) disable iff (rst) dqOeN != 4'hf |-> !csN && edgeCnt >= 16'd23;
    endproperty
    a_first_out: assert property (p_first_out) else $error("output before address done");
    property p_oe_shape;
        @(posedge sclk) disable iff (rst) dqOeN inside {4'hf, 4'hd, 4'hc, 4'h0};
    endproperty
    a_oe_shape: assert property (p_oe_shape) else $error("odd lane enable set");
    c_quad: cover property (@(posedge sclk) disable iff (rst) dqOeN == 4'h0);
    c_dual: cover property (@(posedge sclk) disable iff (rst) dqOeN == 4'hc);
    c_wide: cover property (@(posedge mclk) disable iff (rst) addr4Status);
endmodule
bind sfdp_flash_read sfdp_flash_read_checker u_chk (.mclk(mclk), .rst(rst), .nvAddr4(nvAddr4),
    .addr4Status(addr4Status), .linkBusy(linkBusy), .sclk(sclk), .csN(csN), .dqIn(dqIn),
    .dqOut(dqOut), .dqOeN(dqOeN), .arrayAddr(arrayAddr), .arrayData(arrayData));
`default_nettype wire

// *** sim/tb_top.sv ***
// testbench: host frames on the link, expected bytes from the table and the array pattern
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sfdp_pkg::*;
    // table bytes 30h..53h, 30h in the top byte
    localparam logic [287:0] EXP = 288'he520fbffffffff1f29eb276b273b27bb_ffffffffffff27bbffff29eb0c2010d8_00000000;
    logic mclk, rst, nvAddr4, sclk, csN, addr4Status, linkBusy;
    logic [3:0] dqIn, dqOut, dqOeN, lastOe;
    logic [31:0] arrayAddr;
    logic [7:0] arrayData;
    logic [7:0] got [40]; // bytes of the last frame
    int failures, n_checks;
    int AL [6] = '{1, 1, 1, 2, 1, 4}; // address lanes per read kind
    int DM [6] = '{0, 8, 7, 7, 7, 9}; // dummy cycles
    int DL [6] = '{1, 1, 2, 2, 4, 4}; // data lanes
    logic [7:0] OPS [12] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb,
                             8'h13, 8'h0c, 8'h3c, 8'hbc, 8'h6c, 8'hec};
    sfdp_flash_read dut (.mclk(mclk), .rst(rst), .nvAddr4(nvAddr4), .addr4Status(addr4Status),
        .linkBusy(linkBusy), .sclk(sclk), .csN(csN), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
        .arrayAddr(arrayAddr), .arrayData(arrayData));
    sfdp_array_model mem_model (.arrayAddr(arrayAddr), .arrayData(arrayData));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] mem(input logic [31:0] a);
        return a[7:0] ^ a[31:24] ^ a[23:16];
    endfunction
    // one link period: inputs change while low, host samples at the rise
    task automatic clk1(input logic [3:0] d, output logic [3:0] q);
        dqIn = d;
        #6 sclk = 1'b1;
        q = dqOut;
        lastOe = dqOeN;
        #6 sclk = 1'b0;
    endtask
    task automatic tx(input logic [7:0] b, input int l);
        logic [3:0] q;
        repeat (8 / l) begin
            clk1(4'(b >> (8 - l)), q);
            b = b << l;
        end
    endtask
    // released host lanes toggle so a stale value never reads as data
    task automatic rx(input int l, output logic [7:0] v);
        logic [3:0] q;
        v = 8'h00;
        repeat (8 / l) begin
            clk1(~dqIn, q);
            v = (v << l) | 8'(l == 1 ? {3'b000, q[1]} : q & 4'((1 << l) - 1));
        end
    endtask
    // whole frame; the link clock stands still outside it
    task automatic rd(input logic [7:0] op, input logic [31:0] a, input int na, input int al,
                      input int dm, input int dl, input int n);
        logic [3:0] q;
        @(negedge mclk);
        csN = 1'b0;
        tx(op, 1);
        for (int i = na - 1; i >= 0; i--) tx(a[8*i+:8], al);
        repeat (dm) clk1(~dqIn, q);
        for (int i = 0; i < n; i++) rx(dl, got[i]);
        #6 csN = 1'b1;
        repeat (4) @(negedge mclk);
    endtask
    initial begin
        #3000000;
        failures++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        nvAddr4 = 1'b0;
        sclk = 1'b0;
        csN = 1'b1;
        dqIn = 4'h0;
        failures = 0;
        n_checks = 0;
        repeat (6) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        repeat (4) @(negedge mclk);
        // every read kind: 3-byte forms first at 00ffffffh in die 0, then 4-byte forms at the top of die 1
        // each die is read by a frame of its own
        for (int k = 0; k < 12; k++) begin
            rd(OPS[k], 32'h03ffffff, k > 5 ? 4 : 3, AL[k % 6], DM[k % 6], DL[k % 6], 2);
            chk("first", got[0], mem(k > 5 ? 32'h03ffffff : 32'h00ffffff));
            chk("next", got[1], mem(k > 5 ? 32'h02000000 : 32'h01000000));
            chk("lanes", lastOe, DL[k % 6] == 1 ? 4'hd : DL[k % 6] == 2 ? 4'hc : 4'h0);
        end
        rd(8'h5a, 32'h00000030, 3, 1, 8, 1, 36);
        for (int i = 0; i < 36; i++) begin
            chk("table", got[i], EXP[8*(35-i)+:8]);
        end
        rd(8'h5a, 32'h000007fe, 3, 1, 8, 1, 4);
        chk("twrap", {got[2], got[3]}, 32'h5346);
        // nonvolatile width setting
        @(negedge mclk) nvAddr4 = 1'b1;
        repeat (4) @(negedge mclk);
        // an ignored frame gives the link side edges to take the new setting
        rd(8'hff, 32'h0, 0, 1, 0, 1, 1);
        chk("nvwide", addr4Status, 1'b1);
        rd(8'h03, 32'h02000005, 4, 1, 0, 1, 1);
        chk("nvread", got[0], mem(32'h02000005));
        rd(8'h5a, 32'h00000031, 3, 1, 8, 1, 1);
        chk("disc3", got[0], 32'h20);
        @(negedge mclk) nvAddr4 = 1'b0;
        repeat (4) @(negedge mclk);
        rd(8'hff, 32'h0, 0, 1, 0, 1, 1);
        chk("nvnarrow", addr4Status, 1'b0);
        // command width setting, its frames never drive the lanes
        rd(8'hb7, 32'h0, 0, 1, 0, 1, 1);
        chk("enoe", lastOe, 4'hf);
        chk("cmdwide", addr4Status, 1'b1);
        rd(8'h0b, 32'h01000010, 4, 1, 8, 1, 1);
        chk("cmdread", got[0], mem(32'h01000010));
        rd(8'he9, 32'h0, 0, 1, 0, 1, 1);
        chk("cmdnarrow", addr4Status, 1'b0);
        rd(8'h03, 32'h00000010, 3, 1, 0, 1, 1);
        chk("back3", got[0], mem(32'h00000010));
        end_of_test();
    end
endmodule
`default_nettype wire
